//--- core/shared_fifo_buffer.sv
// shared byte buffer between host registers and internal command logic
// assumes an ahb-lite master with single word transfers and a command
// state machine that samples o_sm_rdata the cycle after i_sm_rd
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ns
// What this block does
// - one 512-entry byte buffer, both directions
// - size select limits capacity to 255 bytes
// - small mode uses one-byte levels, else two
// - single buffer shared with internal state machine
// - flush resets pointers and fill level
// - fill count follows writes and reads
// - write when full sets overflow error flag
// - water level is nine bits over two registers
// - one water level governs both alerts
// - high alert when free space within level
// - low alert when fill within level
// - low alert rise raises enabled interrupt
// - high alert rise raises enabled interrupt
module shared_fifo_buffer
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic i_sm_wr,
   input wire buf_pkg::byte_t i_sm_wdata,
   input wire logic i_sm_rd,
   output buf_pkg::byte_t o_sm_rdata,
   output logic o_sm_empty,
   output logic o_sm_full,
   output logic o_irq
);
   import buf_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic within_level(input cnt_t amount,
                                         input cnt_t level);
      return amount <= level;
   endfunction : within_level

   function automatic logic dp_hit(input logic wr,
                                   input logic [IDX_W-1:0] idx,
                                   input logic [IDX_W-1:0] want);
      return wr && (idx == want);
   endfunction : dp_hit

   buf_mem_if mem_bus ();

   buf_mem u_mem
   (
      .i_clk(i_clk),
      .bus(mem_bus.mem)
   );

   // ==========================================================
   // ahb-lite address phase
   logic dp_wr_q;
   logic [IDX_W-1:0] dp_idx_q;
   logic dp_data_q;
   logic [31:0] rd_q;
   logic [31:0] rd_d;

   wire addr_phase = i_hsel & i_htrans[1] & i_hready;
   wire addr_ok = (i_hsize == HSIZE_WORD) & (i_haddr[1:0] == 2'h0)
                  & (i_haddr[31:IDX_W+2] == '0);
   wire [IDX_W-1:0] a_idx = i_haddr[IDX_W+1:2];
   wire take_rd = addr_phase & ~i_hwrite & addr_ok;
   wire take_wr = addr_phase & i_hwrite & addr_ok;
   wire host_pop_req = take_rd & (a_idx == IDX_DATA);

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         dp_wr_q <= 1'b0;
         dp_idx_q <= IDX_CTRL;
         dp_data_q <= 1'b0;
         rd_q <= 32'h0000_0000;
      end
      else
      begin
         dp_wr_q <= take_wr;
         dp_idx_q <= a_idx;
         dp_data_q <= host_pop_req;
         rd_q <= rd_d;
      end
   end

   // zero wait states, always okay
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // ==========================================================
   // data-phase register writes
   wire wr_ctrl = dp_hit(dp_wr_q, dp_idx_q, IDX_CTRL);
   wire wr_wl_high = dp_hit(dp_wr_q, dp_idx_q, IDX_WL_HIGH);
   wire wr_wl_low = dp_hit(dp_wr_q, dp_idx_q, IDX_WL_LOW);
   wire wr_data = dp_hit(dp_wr_q, dp_idx_q, IDX_DATA);
   wire wr_irq_stat = dp_hit(dp_wr_q, dp_idx_q, IDX_IRQ_STAT);
   wire wr_irq_en = dp_hit(dp_wr_q, dp_idx_q, IDX_IRQ_EN);

   // flush is a strobe only, nothing stores it
   wire flush = wr_ctrl & i_hwdata[CTRL_FLUSH];

   logic size_sel_q;
   ptr_t wl_q;
   logic [IRQ_W-1:0] irq_en_q;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         size_sel_q <= RST_SIZE;
         wl_q <= RST_WL;
         irq_en_q <= RST_IRQ_EN;
      end
      else
      begin
         if (wr_ctrl)
         begin
            size_sel_q <= i_hwdata[CTRL_SIZE];
         end
         if (wr_wl_high)
         begin
            wl_q[8] <= i_hwdata[WL_MSB_BIT];
         end
         if (wr_wl_low)
         begin
            wl_q[7:0] <= i_hwdata[7:0];
         end
         if (wr_irq_en)
         begin
            irq_en_q <= i_hwdata[IRQ_W-1:0];
         end
      end
   end

   // ==========================================================
   // pointers and fill count
   ptr_t wr_ptr_q;
   ptr_t rd_ptr_q;
   cnt_t cnt_q;
   cnt_t cnt_d;

   wire cnt_t cap = size_sel_q ? CAP_SMALL : CAP_FULL;
   wire full = cnt_q >= cap;
   wire empty = cnt_q == '0;
   // the command logic wins a same-cycle collision; the host keeps off
   wire push_req = wr_data | i_sm_wr;
   wire byte_t push_byte = i_sm_wr ? i_sm_wdata : i_hwdata[7:0];
   wire pop_req = host_pop_req | i_sm_rd;
   wire push = push_req & ~full & ~flush;
   wire overflow_ev = push_req & full & ~flush;
   wire pop = pop_req & ~empty & ~flush;

   assign cnt_d = flush ? '0 : cnt_q + CNT_W'(push) - CNT_W'(pop);

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
         if (flush)
         begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
         end
         else
         begin
            wr_ptr_q <= wr_ptr_q + PTR_W'(push);
            rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
         end
      end
   end

   // memory always reads the head; data shows the cycle after a pop
   assign mem_bus.we = push;
   assign mem_bus.waddr = wr_ptr_q;
   assign mem_bus.wdata = push_byte;
   assign mem_bus.raddr = rd_ptr_q;
   assign o_sm_rdata = mem_bus.rdata;
   assign o_sm_empty = empty;
   assign o_sm_full = full;

   // ==========================================================
   // alerts from one shared water level
   // small mode ignores the level's top bit so one byte defines it
   wire cnt_t wl_eff = size_sel_q ? {2'b00, wl_q[7:0]} : {1'b0, wl_q};
   wire high_alert = within_level(cap - cnt_q, wl_eff);
   wire low_alert = within_level(cnt_q, wl_eff);

   logic high_prev_q;
   logic low_prev_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   assign irq_set[IRQ_LOW] = low_alert & ~low_prev_q;
   assign irq_set[IRQ_HIGH] = high_alert & ~high_prev_q;
   assign irq_set[IRQ_ERR] = overflow_ev;
   assign irq_clr = wr_irq_stat ? i_hwdata[IRQ_W-1:0] : '0;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         high_prev_q <= 1'b0;
         // empty buffer starts with the low alert up; that is no rise
         low_prev_q <= 1'b1;
         irq_stat_q <= '0;
      end
      else
      begin
         high_prev_q <= high_alert;
         low_prev_q <= low_alert;
         // set wins over a write-one clear in the same cycle
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      end
   end

   assign o_irq = |(irq_stat_q & irq_en_q);

   // ==========================================================
   // read mux, captured in the address phase
   wire [1:0] lvl_upper = size_sel_q ? 2'b00 : cnt_q[9:8];
   wire [31:0] ctrl_rd = {26'h0, lvl_upper, low_alert, high_alert,
                          size_sel_q, 1'b0};
   wire [31:0] fill_rd = {24'h0, cnt_q[7:0]};
   wire [31:0] wl_high_rd = {29'h0, wl_q[8], 2'h0};
   wire [31:0] wl_low_rd = {24'h0, wl_q[7:0]};
   wire [31:0] stat_rd = {29'h0, irq_stat_q};
   wire [31:0] en_rd = {29'h0, irq_en_q};

   always_comb
   begin
      rd_d = 32'h0000_0000;
      if (take_rd)
      begin
         unique case (a_idx)
            IDX_CTRL: rd_d = ctrl_rd;
            IDX_FILL: rd_d = fill_rd;
            IDX_WL_HIGH: rd_d = wl_high_rd;
            IDX_WL_LOW: rd_d = wl_low_rd;
            IDX_IRQ_STAT: rd_d = stat_rd;
            IDX_IRQ_EN: rd_d = en_rd;
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   assign o_hrdata = dp_data_q ? {24'h0, mem_bus.rdata} : rd_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_push_only;
      push_req && !pop_req && !full && !flush;
   endsequence

   sequence s_empty_pop;
      pop_req && empty && !push_req && !flush;
   endsequence

   a_cap_full_mode: assert property
      (!size_sel_q |-> cnt_q <= 10'd512)
      else $error("fill count above 512");
   a_cap_small_mode: assert property
      (size_sel_q && $past(size_sel_q) && $past(cnt_q) <= 10'd255
       |-> cnt_q <= 10'd255)
      else $error("fill count above 255 in small mode");
   a_level_width: assert property
      (size_sel_q |-> ctrl_rd[5:4] == 2'b00 && wl_eff[9:8] == 2'b00)
      else $error("small mode shows upper level bits");
   a_flush_clears: assert property
      (flush |=> cnt_q == 10'd0 && wr_ptr_q == 9'd0 && rd_ptr_q == 9'd0)
      else $error("flush left pointers or count set");
   a_count_incr: assert property
      (s_push_only |=> cnt_q == $past(cnt_q) + 10'd1)
      else $error("fill count did not follow a write");
   a_overflow_flag: assert property
      (push_req && full && !pop_req && !flush
       |=> irq_stat_q[IRQ_ERR] && cnt_q == $past(cnt_q))
      else $error("overflow not flagged or count moved");
   a_wl_split: assert property
      (wr_wl_high && !wr_wl_low |=> wl_q[8] == $past(i_hwdata[2]))
      else $error("water level top bit not taken");
   a_high_alert: assert property
      (!size_sel_q && cnt_q == 10'd512 |-> high_alert)
      else $error("high alert clear while full");
   a_low_alert: assert property
      (cnt_q == 10'd0 |-> low_alert)
      else $error("low alert clear when empty");
   a_low_above_level: assert property
      (cnt_q == wl_eff + 10'd1 |-> !low_alert)
      else $error("low alert set above the water level");
   a_irq_low: assert property
      (irq_en_q[IRQ_LOW] && !wr_irq_en && low_alert && !low_prev_q
       |=> o_irq)
      else $error("low alert rise gave no interrupt");
   a_irq_high: assert property
      (irq_en_q[IRQ_HIGH] && !wr_irq_en && high_alert && !high_prev_q
       |=> o_irq)
      else $error("high alert rise gave no interrupt");
   a_no_underflow: assert property
      (s_empty_pop |=> cnt_q == 10'd0 && rd_ptr_q == $past(rd_ptr_q))
      else $error("empty read moved the buffer");
   a_flush_reads_zero: assert property
      (take_rd && a_idx == IDX_CTRL |=> o_hrdata[CTRL_FLUSH] == 1'b0)
      else $error("flush bit read back as one");
endmodule : shared_fifo_buffer

//--- shared/buf_pkg.sv
// constants for the shared byte buffer: register indices, field positions,
// reset values and sizes
// assumes a 32-bit ahb-lite register bus, one word per register
package buf_pkg;
   // ==========================================================
   // sizes
   localparam int DATA_W = 8;
   localparam int PTR_W = 9;
   localparam int CNT_W = 10;
   localparam int IDX_W = 3;
   localparam logic [CNT_W-1:0] CAP_FULL = 10'h200;
   localparam logic [CNT_W-1:0] CAP_SMALL = 10'h0ff;
   // ==========================================================
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL = 3'h0;
   localparam logic [IDX_W-1:0] IDX_FILL = 3'h1;
   localparam logic [IDX_W-1:0] IDX_WL_HIGH = 3'h2;
   localparam logic [IDX_W-1:0] IDX_WL_LOW = 3'h3;
   localparam logic [IDX_W-1:0] IDX_DATA = 3'h4;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 3'h5;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN = 3'h6;
   // ==========================================================
   // field positions
   localparam int CTRL_FLUSH = 0;
   localparam int CTRL_SIZE = 1;
   localparam int CTRL_HIGH = 2;
   localparam int CTRL_LOW = 3;
   localparam int CTRL_LVL_LSB = 4;
   localparam int WL_MSB_BIT = 2;
   localparam int IRQ_LOW = 0;
   localparam int IRQ_HIGH = 1;
   localparam int IRQ_ERR = 2;
   localparam int IRQ_W = 3;
   // ==========================================================
   // reset values and bus codes
   localparam logic RST_SIZE = 1'b0;
   localparam logic [PTR_W-1:0] RST_WL = 9'h000;
   localparam logic [IRQ_W-1:0] RST_IRQ_EN = 3'h0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef logic [DATA_W-1:0] byte_t;
   typedef logic [PTR_W-1:0] ptr_t;
   typedef logic [CNT_W-1:0] cnt_t;
endpackage : buf_pkg

//--- shared/buf_mem_if.sv
// carrier between the buffer controller and its byte memory
// assumes one write port and one registered read port on one clock
`timescale 1ns/1ns
interface buf_mem_if;
   logic we;
   buf_pkg::ptr_t waddr;
   buf_pkg::byte_t wdata;
   buf_pkg::ptr_t raddr;
   buf_pkg::byte_t rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr,
                 input rdata);
   modport mem (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface : buf_mem_if

//--- core/buf_mem.sv
// 512 x 8 storage for the shared buffer
// assumes the controller keeps pointers in range; read data is registered
`timescale 1ns/1ns
module buf_mem
(
   input wire logic i_clk,
   buf_mem_if.mem bus
);
   import buf_pkg::*;

   byte_t mem_q [0:511];
   byte_t rdata_q;

   // ==========================================================
   // storage; no reset, contents are undefined until written
   always_ff @(posedge i_clk)
   begin
      if (bus.we)
      begin
         mem_q[bus.waddr] <= bus.wdata;
      end
      rdata_q <= mem_q[bus.raddr];
   end

   assign bus.rdata = rdata_q;
endmodule : buf_mem

//--- verification/cmd_sm_model.sv
// stand-in for the internal command state machine on the buffer side
// assumes the bench calls push and pop one at a time, never with host
// traffic to the data register in the same cycle
`timescale 1ns/1ns
module cmd_sm_model
   import buf_pkg::*;
(
   input wire logic i_clk,
   output logic o_wr,
   output buf_pkg::byte_t o_wdata,
   output logic o_rd,
   input wire buf_pkg::byte_t i_rdata
);
   // ==========================================================
   // byte transfers
   initial
   begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end
   // one pulse per byte; idle data is inverted so stale values never match
   task automatic push(input byte_t b);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_wdata <= b;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~b;
   endtask : push
   // popped byte stands from before the pulse until the end of the cycle after it
   task automatic pop(output byte_t b);
      @(posedge i_clk);
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      @(posedge i_clk);
      b = i_rdata;
   endtask : pop
endmodule : cmd_sm_model

//--- verification/testbench.sv
// self-checking bench for the shared byte buffer
// assumes a zero-wait ahb-lite slave and the command model beside it
`timescale 1ns/1ns
module testbench;
   import buf_pkg::*;
   logic i_clk, i_rst, hsel, hwrite, hrdy, hresp;
   logic sm_wr, sm_rd, empty, full, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, r;
   byte_t sm_wdata, sm_rdata, b;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   // ==========================================================
   // clock, watchdog, design and partner
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // ceiling well above the ~3700 cycles the sequence needs
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   shared_fifo_buffer shared_fifo_buffer_inst (.i_clk(i_clk),
      .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hrdy),
      .i_hwdata(hwdata), .o_hreadyout(hrdy), .o_hresp(hresp),
      .o_hrdata(hrdata), .i_sm_wr(sm_wr), .i_sm_wdata(sm_wdata),
      .i_sm_rd(sm_rd), .o_sm_rdata(sm_rdata), .o_sm_empty(empty),
      .o_sm_full(full), .o_irq(irq));
   cmd_sm_model cmd_sm_model_inst (.i_clk(i_clk), .o_wr(sm_wr),
      .o_wdata(sm_wdata), .o_rd(sm_rd), .i_rdata(sm_rdata));
   // ==========================================================
   // bus and compare tasks
   task automatic bus(input logic w, input logic [2:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge i_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {27'h0, idx, 2'b00};
      hsize <= HSIZE_WORD;
      do @(posedge i_clk); while (hrdy !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge i_clk); while (hrdy !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask : bus
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask : wr
   task automatic rc(input logic [2:0] idx, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, idx, 32'h0, x);
      chk($sformatf("reg%0d", idx), e, x);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rc
   function automatic logic [31:0] pat(input int k);
      return {24'h0, k[7:0] ^ 8'h5a};
   endfunction : pat
   task automatic tally_and_finish();
      if (n_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   // ==========================================================
   // sequence
   initial
   begin
      i_rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      hsize = HSIZE_WORD;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      rc(IDX_CTRL, 32'h8);
      rc(IDX_WL_LOW, 32'h0);
      rc(IDX_IRQ_EN, 32'h0);
      rc(IDX_IRQ_STAT, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      chk("empty", 32'h1, {31'h0, empty});
      // water level 256 spread over two registers
      wr(IDX_WL_HIGH, 32'h4);
      rc(IDX_WL_HIGH, 32'h4);
      wr(IDX_IRQ_EN, 32'h7);
      for (int i = 0; i < 3; i++) wr(IDX_DATA, pat(i));
      rc(IDX_FILL, 32'h3);
      cmd_sm_model_inst.pop(b);
      chk("pop", pat(0), {24'h0, b});
      rc(IDX_DATA, pat(1));
      rc(IDX_FILL, 32'h1);
      wr(IDX_CTRL, 32'h1);
      rc(IDX_CTRL, 32'h8);
      rc(IDX_FILL, 32'h0);
      wr(IDX_IRQ_STAT, 32'h7);
      // fill from both sides up to 512
      for (int i = 0; i < 512; i++)
         if (i < 256) wr(IDX_DATA, pat(i));
         else cmd_sm_model_inst.push(byte_t'(pat(i)));
      rc(IDX_CTRL, 32'h24);
      chk("full", 32'h1, {31'h0, full});
      chk("empty", 32'h0, {31'h0, empty});
      wr(IDX_DATA, 32'hee);
      rc(IDX_IRQ_STAT, 32'h6);
      chk("irq", 32'h1, {31'h0, irq});
      rc(IDX_CTRL, 32'h24);
      wr(IDX_IRQ_STAT, 32'h7);
      // the clear lands on the edge that ends the write; look one later
      @(posedge i_clk);
      chk("irq", 32'h0, {31'h0, irq});
      for (int i = 0; i < 512; i++)
      begin
         cmd_sm_model_inst.pop(b);
         chk("pop", pat(i), {24'h0, b});
      end
      rc(IDX_IRQ_STAT, 32'h1);
      rc(IDX_CTRL, 32'h8);
      chk("empty", 32'h1, {31'h0, empty});
      bus(1'b0, IDX_DATA, 32'h0, r);
      rc(IDX_CTRL, 32'h8);
      rc(IDX_FILL, 32'h0);
      wr(IDX_DATA, 32'h3c);
      rc(IDX_DATA, 32'h3c);
      // small mode: level bit 8 is ignored, so the level is 0
      wr(IDX_CTRL, 32'h2);
      rc(IDX_CTRL, 32'ha);
      for (int i = 0; i < 255; i++) wr(IDX_DATA, pat(i));
      rc(IDX_CTRL, 32'h6);
      rc(IDX_FILL, 32'hff);
      wr(IDX_IRQ_STAT, 32'h7);
      wr(IDX_DATA, 32'h0);
      rc(IDX_IRQ_STAT, 32'h4);
      rc(IDX_FILL, 32'hff);
      rc(3'h7, 32'h0);
      tally_and_finish();
   end
endmodule : testbench
